/* design/sbrg_pkg.sv */
// Constants for the serial bit-rate generator.
// Assumes a single system clock domain; no software-reachable registers.
package sbrg_pkg;
  // Reference and internal clock figures in Hz.
  localparam int unsigned REF_CLK_HZ        = 14745600;
  localparam int unsigned CLK_MULT_FACTOR   = 2;
  localparam int unsigned INT_CLK_HZ        = REF_CLK_HZ * CLK_MULT_FACTOR;
  // Clock multiplier control codes for factors of one and two; reset selects two.
  localparam logic [1:0]  MULT_X1           = 2'h0;
  localparam logic [1:0]  MULT_X2           = 2'h1;
  localparam logic [1:0]  MULT_RESET        = MULT_X2;
  // Base prescale: thirty-two internal clocks per bit at select 0, divisor 0.
  // This is what makes divisor 7 at select 0 land exactly on 115200 baud.
  localparam int unsigned BASE_PRESCALE     = 32;
  localparam int unsigned PRESCALE_W        = 12;
  localparam int unsigned DIV_W             = 8;
  localparam logic [1:0]  SEL_RESET         = 2'h0;
  localparam logic [7:0]  DIV_RESET         = 8'h07;
  // Sample tick rate is sixteen per bit, for a receiver oversampler.
  localparam int unsigned OVERSAMPLE        = 16;
  localparam logic [3:0]  OVS_LAST          = 4'hf;
  // Rate errors for the documented pairs; avoid these combinations.
  localparam logic [7:0]  BAD_DIV_SEL3_9600 = 8'h01;
  localparam logic [7:0]  BAD_DIV_SEL2_38400 = 8'h01;
  localparam int unsigned LEVEL_CONV_MAX_BAUD = 120000;
endpackage : sbrg_pkg

/* design/sbrg_clk_mult.sv */
// Internal clock-enable multiplier: emits internal-rate ticks from the reference tick.
// Assumes i_ref_tick pulses once per reference clock period on i_clk_sys.
`timescale 1ns/10ps
module sbrg_clk_mult
  import sbrg_pkg::*;
(
  // Clock, reset and enable
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_n,
  input  wire logic       i_ce,
  // Control
  input  wire logic [1:0] i_mult,
  input  wire logic       i_ref_tick,
  // Internal tick
  output logic            o_int_tick
);
  typedef struct packed {
    logic ph;
    logic tick;
  } sbrg_cm_t;

  sbrg_cm_t st;
  sbrg_cm_t next_st;

  // With factor two each reference tick yields two internal ticks, one on the next cycle and one on the cycle after.
  always_comb
  begin
    next_st      = st;
    next_st.tick = 1'b0;
    if (i_ref_tick)
    begin
      next_st.tick = 1'b1;
      next_st.ph   = (i_mult == MULT_X2);
    end
    else if (st.ph)
    begin
      next_st.tick = 1'b1;
      next_st.ph   = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      st <= '0;
    else if (i_ce)
      st <= next_st;
  end

  assign o_int_tick = st.tick;
endmodule : sbrg_clk_mult

/* design/sbrg_baud_gen.sv */
// Serial bit-rate generator: internal clock over 32*4^select*(divisor+1).
// Assumes settings arrive from same-clock logic and the reference tick is same-clock.
// What this block does
// - Internal rate is once or twice the reference, set by the clock multiplier control.
// - Select 0 with divisors 7, 23, 95, 191 gives exact standard rates.
// - Select 1 with divisors 1, 11, 47, 191 gives exact standard rates.
// - Select 2 divisors 0, 5 and select 3 divisors 47, 130 give listed rates.
`timescale 1ns/10ps
module sbrg_baud_gen
  import sbrg_pkg::*;
(
  // Clock, reset and enable
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst_n,
  input  wire logic             i_ce,
  // Reference timing
  input  wire logic             i_ref_tick,
  // Settings
  input  wire logic [1:0]       i_clock_multiplier_control,
  input  wire logic [1:0]       i_serial_clock_select,
  input  wire logic [DIV_W-1:0] i_bit_rate_divisor,
  input  wire logic             i_load,
  // Outputs
  output logic                  o_sample_tick,
  output logic                  o_bit_tick,
  output logic                  o_int_tick,
  output logic [1:0]            o_serial_clock_select,
  output logic [DIV_W-1:0]      o_bit_rate_divisor
);
  import sbrg_pkg::*;

  typedef struct packed {
    logic [1:0]            mult;
    logic [1:0]            sel;
    logic [DIV_W-1:0]      div;
    logic [PRESCALE_W-1:0] pre_cnt;
    logic [DIV_W-1:0]      div_cnt;
    logic [3:0]            ovs_cnt;
    logic                  sample_tick;
    logic                  bit_tick;
    logic                  int_tick;
  } sbrg_st_t;

  sbrg_st_t st;
  sbrg_st_t next_st;
  logic     int_tick_raw;
  logic     rst_sync_n;
  logic     rst_q1;
  logic     rst_q2;

  // Prescale length in internal ticks per divisor count step: 2 * 4^select.
  function automatic logic [PRESCALE_W-1:0] prescale_last(input logic [1:0] sel);
    logic [PRESCALE_W-1:0] full;
    full = PRESCALE_W'((BASE_PRESCALE / OVERSAMPLE)) << {sel, 1'b0};
    prescale_last = full - PRESCALE_W'(1);
  endfunction : prescale_last

  // Reset is released through two flip-flops; the asynchronous edge still clears at once.
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rst_q1 <= 1'b0;
      rst_q2 <= 1'b0;
    end
    else
    begin
      rst_q1 <= 1'b1;
      rst_q2 <= rst_q1;
    end
  end
  assign rst_sync_n = rst_q2;

  sbrg_clk_mult u_clk_mult
  (
    .i_clk_sys  (i_clk_sys),
    .i_rst_n    (rst_sync_n),
    .i_ce       (i_ce),
    .i_mult     (st.mult),
    .i_ref_tick (i_ref_tick),
    .o_int_tick (int_tick_raw)
  );

  always_comb
  begin
    next_st             = st;
    next_st.sample_tick = 1'b0;
    next_st.bit_tick    = 1'b0;
    next_st.int_tick    = int_tick_raw;
    if (i_load)
    begin
      // New settings restart the divider chain so the first bit after a change has full length.
      next_st.mult    = i_clock_multiplier_control;
      next_st.sel     = i_serial_clock_select;
      next_st.div     = i_bit_rate_divisor;
      next_st.pre_cnt = '0;
      next_st.div_cnt = '0;
      next_st.ovs_cnt = '0;
    end
    else if (int_tick_raw)
    begin
      if (st.pre_cnt >= prescale_last(st.sel))
      begin
        next_st.pre_cnt = '0;
        if (st.div_cnt >= st.div)
        begin
          next_st.div_cnt     = '0;
          next_st.sample_tick = 1'b1;
          next_st.ovs_cnt     = st.ovs_cnt + 4'h1;
          // Sixteen sample ticks make one bit period.
          next_st.bit_tick    = (st.ovs_cnt == OVS_LAST);
        end
        else
          next_st.div_cnt = st.div_cnt + DIV_W'(1);
      end
      else
        next_st.pre_cnt = st.pre_cnt + PRESCALE_W'(1);
    end
  end

  // The two synchroniser stages are held in their own process above.
  always_ff @(posedge i_clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      st.mult        <= MULT_RESET;
      st.sel         <= SEL_RESET;
      st.div         <= DIV_RESET;
      st.pre_cnt     <= '0;
      st.div_cnt     <= '0;
      st.ovs_cnt     <= '0;
      st.sample_tick <= 1'b0;
      st.bit_tick    <= 1'b0;
      st.int_tick    <= 1'b0;
    end
    else if (i_ce)
      st <= next_st;
  end

  assign o_sample_tick         = st.sample_tick;
  assign o_bit_tick            = st.bit_tick;
  assign o_int_tick            = st.int_tick;
  assign o_serial_clock_select = st.sel;
  assign o_bit_rate_divisor    = st.div;
endmodule : sbrg_baud_gen

/* bench/sbrg_chk.sv */
// Port checker for the bit-rate generator.
// Assumes it is bound onto sbrg_baud_gen.
`timescale 1ns/10ps
module sbrg_chk (
  input wire logic       i_clk_sys,
  input wire logic       i_rst_n,
  input wire logic       i_ce,
  input wire logic       i_load,
  input wire logic [1:0] i_serial_clock_select,
  input wire logic [7:0] i_bit_rate_divisor,
  input wire logic       o_sample_tick,
  input wire logic       o_bit_tick,
  input wire logic [1:0] o_serial_clock_select,
  input wire logic [7:0] o_bit_rate_divisor
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  property p_sel;
    i_load && i_ce |=> o_serial_clock_select == $past(i_serial_clock_select);
  endproperty
  a_sel: assert property (p_sel) else $error("select not taken");
  property p_div;
    i_load && i_ce |=> o_bit_rate_divisor == $past(i_bit_rate_divisor);
  endproperty
  a_div: assert property (p_div) else $error("divisor not taken");
  property p_bit_on_sample;
    o_bit_tick |-> o_sample_tick;
  endproperty
  a_bit_on_sample: assert property (p_bit_on_sample) else $error("bit tick off sample");
  property p_bit_pulse;
    o_bit_tick |=> !o_bit_tick [*3];
  endproperty
  a_bit_pulse: assert property (p_bit_pulse) else $error("bit tick too close");
  property p_hold;
    !i_load |=> $stable(o_bit_rate_divisor) && $stable(o_serial_clock_select);
  endproperty
  a_hold: assert property (p_hold) else $error("settings moved");
  c_load: cover property (i_load && i_ce);
  c_bit: cover property (o_bit_tick);
  c_sel2: cover property (o_bit_tick && o_serial_clock_select == 2'h2);
endmodule : sbrg_chk
bind sbrg_baud_gen sbrg_chk i_chk (.*);

/* bench/sbrg_ref_model.sv */
// Reference clock source seen by the generator.
// Assumes one tick every second system clock, the fastest allowed.
`timescale 1ns/10ps
module sbrg_ref_model (
  input  wire logic i_clk_sys,
  input  wire logic i_rst_n,
  output logic      o_ref_tick
);
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
    if (!i_rst_n)
      o_ref_tick <= 1'b0;
    else
      o_ref_tick <= !o_ref_tick;
endmodule : sbrg_ref_model

/* bench/tb_top.sv */
// Self-checking bench for the bit-rate generator.
// Assumes the reference model drives the reference tick.
`timescale 1ns/10ps
module tb_top;
  import sbrg_pkg::*;
  logic       clk = 0, rst_n = 0, ce = 1, load = 0, rt, st, bt, it;
  logic [1:0] mult = MULT_X2, sel = 0, osel;
  logic [7:0] div = 0, odiv;
  int         errors = 0, check_count = 0;
  initial forever #4 clk = !clk;
  sbrg_ref_model i_ref (.i_clk_sys(clk), .i_rst_n(rst_n), .o_ref_tick(rt));
  sbrg_baud_gen i_dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_ce(ce), .i_ref_tick(rt),
    .i_clock_multiplier_control(mult), .i_serial_clock_select(sel), .i_bit_rate_divisor(div),
    .i_load(load), .o_sample_tick(st), .o_bit_tick(bt), .o_int_tick(it),
    .o_serial_clock_select(osel), .o_bit_rate_divisor(odiv));
  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
      errors++;
    end
  endtask : chk
  task results;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results
  // Loads a setting, then counts ticks across one whole bit period.
  task meas(input logic [1:0] m, input logic [1:0] s, input logic [7:0] d);
    int e, ni, ns, nr, k;
    e = BASE_PRESCALE * (1 << (2 * s)) * (d + 1);
    @(posedge clk);
    mult <= m;
    sel <= s;
    div <= d;
    load <= 1;
    @(posedge clk);
    load <= 0;
    @(negedge clk);
    chk({odiv, 6'h0, osel}, {d, 6'h0, s});
    for (k = 0; !bt; k++)
    begin
      @(negedge clk);
      if (k > 30000)
      begin
        errors++;
        results();
      end
    end
    ni = 0;
    ns = 0;
    nr = 0;
    do
    begin
      @(negedge clk);
      ni += it;
      ns += st;
      nr += rt;
    end while (!bt && ni < 70000);
    chk(ni, e);
    chk(ns, 16);
    chk(nr, (m == MULT_X2) ? e / 2 : e);
  endtask : meas
  // Slow selects: one sample period, a sixteenth of a bit, keeps the run short.
  task meas_smp(input logic [1:0] s, input logic [7:0] d);
    int e, ni, k;
    e = (BASE_PRESCALE / OVERSAMPLE) * (1 << (2 * s)) * (d + 1);
    @(posedge clk);
    mult <= MULT_X2;
    sel <= s;
    div <= d;
    load <= 1;
    @(posedge clk);
    load <= 0;
    @(negedge clk);
    for (k = 0; !st; k++)
    begin
      @(negedge clk);
      if (k > 20000)
      begin
        errors++;
        results();
      end
    end
    ni = 0;
    do
    begin
      @(negedge clk);
      ni += it;
    end while (!st && ni < 70000);
    chk(ni, e);
  endtask : meas_smp
  // Enable low must freeze every output and ignore a load.
  task t_ce;
    logic [12:0] v;
    meas(MULT_X2, 0, 7);
    @(posedge clk);
    ce <= 0;
    @(negedge clk);
    v = {st, bt, it, osel, odiv};
    @(posedge clk);
    sel <= 2'h2;
    div <= 8'h05;
    load <= 1;
    @(posedge clk);
    load <= 0;
    repeat (40) @(posedge clk);
    @(negedge clk);
    chk({19'h0, st, bt, it, osel, odiv}, {19'h0, v});
    @(posedge clk);
    ce <= 1;
    $display("test enable done");
  endtask : t_ce
  task t_rates;
    meas(MULT_X2, 0, 7);
    meas(MULT_X2, 0, 23);
    meas(MULT_X2, 0, 95);
    meas(MULT_X2, 1, 1);
    meas(MULT_X2, 1, 11);
    meas(MULT_X2, 1, 47);
    meas(MULT_X2, 2, 0);
    meas(MULT_X2, 2, 5);
    meas_smp(3, 47);
    meas_smp(3, 130);
    $display("test rates done");
  endtask : t_rates
  task t_mult;
    meas(MULT_X1, 0, 0);
    meas(MULT_X2, 0, 0);
    $display("test multiplier done");
  endtask : t_mult
  initial
  begin
    repeat (3) @(posedge clk);
    chk({odiv, 6'h0, osel}, {DIV_RESET, 6'h0, SEL_RESET});
    repeat (3) @(posedge clk);
    rst_n <= 1;
    repeat (4) @(posedge clk);
    t_mult();
    t_ce();
    t_rates();
    results();
  end
endmodule : tb_top
